// *** hw/chs_pkg.sv ***
package chs_pkg;

	// ****************************************
	// Serial port and register file
	// ****************************************
	localparam logic [6:0]  I2C_ADDR    = 7'h6b;
	localparam int          NREG        = 38;
	localparam logic [7:0]  LAST_REG    = 8'h25;
	localparam logic [7:0]  OOR_DATA    = 8'hff;
	localparam logic [7:0]  WD_REG      = 8'h05;
	localparam int          WD_SEL_LSB  = 4;
	localparam int          WD_KICK_BIT = 3;
	localparam logic [7:0]  STAT_REG    = 8'h0b;
	localparam logic [7:0]  FLAG_REG    = 8'h0f;
	localparam logic [7:0]  MASK_REG    = 8'h12;
	localparam int          EV_HTO      = 0;
	localparam int          EV_SAFE     = 1;
	localparam logic [37:0] REG_WR_MASK = 38'h20007c03ff;
	localparam logic [303:0] REG_RST    = 304'h54a0;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_MHZ       = 100;
	localparam int INT_PULSE_US  = 256;
	localparam int INT_PULSE_CYC = INT_PULSE_US * CLK_MHZ;
	localparam int TICK_US       = 1000;
	localparam int TICK_CYC      = TICK_US * CLK_MHZ;
	localparam int SAFETY_HOURS  = 10;
	localparam int SAFETY_MS     = SAFETY_HOURS * 3600 * 1000;
	localparam int WD1_S         = 40;
	localparam int WD2_S         = 80;
	localparam int WD3_S         = 160;

	// ****************************************
	// Bus registers
	// ****************************************
	localparam logic [7:0] AHB_CTRL    = 8'h00;
	localparam logic [7:0] AHB_STATUS  = 8'h04;
	localparam logic [7:0] AHB_PTR     = 8'h08;
	localparam int         CTRL_CHG    = 0;
	localparam int         CTRL_STRCH  = 1;

	typedef enum logic [2:0] {ST_IDLE, ST_DEV, ST_PTR, ST_WR, ST_RD, ST_ACK, ST_MACK} chs_state_e;

endpackage

// *** hw/chs_slave.sv ***
`timescale 1ns/1ps
// What this block does
// - Answers only when the address byte after start equals the fixed address.
// - Works at standard and fast bus speeds.
// - Data line changes only while clock is low, stable while high.
// - Start is data falling with clock high; stop is data rising with clock high.
// - Only the master makes start and stop; bus busy from start until stop.
// - Bytes are eight bits, MSB first, any number per transfer.
// - On the ninth pulse transmitter releases data; accepting receiver holds it low.
// - Data high on the ninth pulse is a not-acknowledge; master then stops or restarts.
// - Device may hold clock low; master waits until it is released.
// - First byte is seven address bits plus direction, zero write, one read.
// - Undefined register address gets not-acknowledge and the port goes idle.
// - Multi-byte reads work across all registers; multi-byte writes change only the writable ones.
// - Host-timeout status is high in default mode, low in host mode.
// - After power-on: default mode, watchdog expired, registers at defaults.
// - Default mode charges under a ten-hour safety timer, then stops charging.
// - Any register write enters host mode and starts the watchdog.
// - Watchdog expiry sets status, returns to default mode, restores defaults.
// - Each unmasked event gives one active-low 256 us interrupt pulse.
// - Power-up gives an interrupt pulse to show the port is ready.
// - Event flags clear on read; set again only on a new rising edge.
module chs_slave
	import chs_pkg::*;
#(
	parameter int INT_CYC    = INT_PULSE_CYC,
	parameter int TICK_CYCS  = TICK_CYC,
	parameter int SAFETY_TKS = SAFETY_MS,
	parameter int WD1_TKS    = WD1_S * 1000,
	parameter int WD2_TKS    = WD2_S * 1000,
	parameter int WD3_TKS    = WD3_S * 1000
) (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Serial pins
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe,
	// Device status
	output logic             int_n,
	output logic             host_timeout_status,
	output logic             charge_active
);

	// ****************************************
	// Pin synchronisers and bus conditions
	// ****************************************
	logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
			{sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
		end else begin
			{scl_m_q, scl_s_q, scl_p_q} <= {scl_i, scl_m_q, scl_s_q};
			{sda_m_q, sda_s_q, sda_p_q} <= {sda_i, sda_m_q, sda_s_q};
		end
	end

	logic start, stop, rise, fall;
	assign start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
	assign stop  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
	assign rise  = scl_s_q & ~scl_p_q;
	assign fall  = ~scl_s_q & scl_p_q;

	// ****************************************
	// Serial slave and register file
	// ****************************************
	chs_state_e  st_q, st_d, nxt_q, nxt_d;
	logic [2:0]  cnt_q, cnt_d;
	logic [7:0]  sh_q, sh_d, ptr_q, ptr_d, rd_byte, b;
	logic        ack_q, ack_d, ackp_q, ackp_d, oe_q, oe_d, strch_q, strch_d, busy_q, busy_d;
	logic [7:0]  regs_q [NREG];
	logic [7:0]  regs_d [NREG];
	logic        i2c_wr, kick, rd_clear, wd_exp, host_mode_q, safe_exp_q;
	logic [1:0]  flag_q, ctrl_q;

	always_comb begin
		if (ptr_q > LAST_REG)
			rd_byte = OOR_DATA;
		else if (ptr_q == STAT_REG)
			rd_byte = {6'h0, safe_exp_q, ~host_mode_q};
		else if (ptr_q == FLAG_REG)
			rd_byte = {6'h0, flag_q};
		else
			rd_byte = regs_q[ptr_q[5:0]];
	end

	always_comb begin
		st_d     = st_q;
		nxt_d    = nxt_q;
		cnt_d    = cnt_q;
		sh_d     = sh_q;
		ptr_d    = ptr_q;
		ack_d    = ack_q;
		ackp_d   = ackp_q;
		oe_d     = oe_q;
		busy_d   = busy_q;
		strch_d  = strch_q & ctrl_q[CTRL_STRCH];
		regs_d   = regs_q;
		i2c_wr   = 1'b0;
		kick     = 1'b0;
		rd_clear = 1'b0;
		b        = {sh_q[6:0], sda_s_q};
		regs_d[WD_REG[5:0]][WD_KICK_BIT] = 1'b0;
		if (start) begin
			st_d   = ST_DEV;
			cnt_d  = 3'h0;
			oe_d   = 1'b0;
			busy_d = 1'b1;
		end else if (stop) begin
			st_d   = ST_IDLE;
			oe_d   = 1'b0;
			busy_d = 1'b0;
		end else begin
			case (st_q)
				ST_DEV, ST_PTR, ST_WR: begin
					if (rise) begin
						sh_d  = b;
						cnt_d = cnt_q + 3'h1;
						if (cnt_q == 3'h7) begin
							st_d   = ST_ACK;
							ackp_d = 1'b0;
							ack_d  = 1'b1;
							if (st_q == ST_DEV) begin
								if (b[7:1] != I2C_ADDR)
									st_d = ST_IDLE;
								nxt_d = b[0] ? ST_RD : ST_PTR;
							end else if (st_q == ST_PTR) begin
								if (b > LAST_REG) begin
									ack_d = 1'b0;
									nxt_d = ST_IDLE;
								end else begin
									ptr_d = b;
									nxt_d = ST_WR;
								end
							end else begin
								nxt_d  = ST_WR;
								ptr_d  = ptr_q + 8'h01;
								i2c_wr = 1'b1;
								if (ptr_q <= LAST_REG && REG_WR_MASK[ptr_q[5:0]]) begin
									regs_d[ptr_q[5:0]] = b;
									kick = (ptr_q == WD_REG) && b[WD_KICK_BIT];
									regs_d[ptr_q[5:0]][WD_KICK_BIT] = (ptr_q == WD_REG) ? 1'b0
										: b[WD_KICK_BIT];
								end
							end
						end
					end
				end
				ST_ACK: begin
					if (fall && !ackp_q) begin
						oe_d   = ack_q;
						ackp_d = 1'b1;
					end else if (fall) begin
						st_d    = nxt_q;
						cnt_d   = 3'h0;
						oe_d    = 1'b0;
						strch_d = ctrl_q[CTRL_STRCH];
						if (nxt_q == ST_RD) begin
							sh_d     = rd_byte;
							oe_d     = ~rd_byte[7];
							rd_clear = (ptr_q == FLAG_REG);
						end
					end
				end
				ST_RD: begin
					if (fall) begin
						cnt_d = cnt_q + 3'h1;
						if (cnt_q == 3'h7) begin
							oe_d   = 1'b0;
							st_d   = ST_MACK;
							ackp_d = 1'b0;
							ptr_d  = ptr_q + 8'h01;
						end else begin
							sh_d = {sh_q[6:0], 1'b0};
							oe_d = ~sh_q[6];
						end
					end
				end
				ST_MACK: begin
					if (rise && sda_s_q)
						st_d = ST_IDLE;
					else if (rise)
						ackp_d = 1'b1;
					else if (fall && ackp_q) begin
						st_d     = ST_RD;
						cnt_d    = 3'h0;
						sh_d     = rd_byte;
						oe_d     = ~rd_byte[7];
						rd_clear = (ptr_q == FLAG_REG);
					end
				end
				default: st_d = ST_IDLE;
			endcase
		end
		if (wd_exp) begin
			for (int i = 0; i < NREG; i++) begin
				if (REG_WR_MASK[i])
					regs_d[i] = REG_RST[i*8 +: 8];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q    <= ST_IDLE;
			nxt_q   <= ST_IDLE;
			cnt_q   <= 3'h0;
			sh_q    <= 8'h00;
			ptr_q   <= 8'h00;
			ack_q   <= 1'b0;
			ackp_q  <= 1'b0;
			oe_q    <= 1'b0;
			strch_q <= 1'b0;
			busy_q  <= 1'b0;
			for (int i = 0; i < NREG; i++)
				regs_q[i] <= REG_RST[i*8 +: 8];
		end else begin
			st_q    <= st_d;
			nxt_q   <= nxt_d;
			cnt_q   <= cnt_d;
			sh_q    <= sh_d;
			ptr_q   <= ptr_d;
			ack_q   <= ack_d;
			ackp_q  <= ackp_d;
			oe_q    <= oe_d;
			strch_q <= strch_d;
			busy_q  <= busy_d;
			regs_q  <= regs_d;
		end
	end

	// Open-drain: only ever pull low
	assign sda_o  = 1'b0;
	assign sda_oe = oe_q;
	assign scl_o  = 1'b0;
	assign scl_oe = strch_q;

	// ****************************************
	// Mode, watchdog, safety timer, interrupt
	// ****************************************
	logic [31:0] tick_q, tick_d, wd_q, wd_d, safe_q, safe_d, int_q, int_d, wd_to;
	logic        host_mode_d, safe_exp_d, int_n_q, tick;
	logic [1:0]  flag_d, stat, stat_p_q, new_ev, mask_p_q;

	assign tick = (tick_q == 32'(TICK_CYCS - 1));
	assign stat = {safe_exp_q, ~host_mode_q};

	always_comb begin
		case (regs_q[WD_REG[5:0]][WD_SEL_LSB +: 2])
			2'h1:    wd_to = 32'(WD1_TKS);
			2'h2:    wd_to = 32'(WD2_TKS);
			2'h3:    wd_to = 32'(WD3_TKS);
			default: wd_to = 32'h0;
		endcase
		// Expiry is judged only on tick edges; a zero select never fires because wd_to is then zero
		wd_exp = host_mode_q && tick && (wd_to != 32'h0) && (wd_q >= wd_to - 32'h1);
	end

	always_comb begin
		tick_d      = tick ? 32'h0 : tick_q + 32'h1;
		host_mode_d = host_mode_q;
		wd_d        = (tick && host_mode_q) ? wd_q + 32'h1 : wd_q;
		if (i2c_wr || kick) begin
			host_mode_d = 1'b1;
			wd_d        = 32'h0;
		end
		if (wd_exp) begin
			host_mode_d = 1'b0;
			wd_d        = 32'h0;
		end
		safe_d     = safe_q;
		safe_exp_d = safe_exp_q;
		if (!ctrl_q[CTRL_CHG]) begin
			safe_d     = 32'h0;
			safe_exp_d = 1'b0;
		end else if (!host_mode_q && !safe_exp_q && tick) begin
			safe_d = safe_q + 32'h1;
			if (safe_q == 32'(SAFETY_TKS - 1))
				safe_exp_d = 1'b1;
		end
		new_ev = stat & ~stat_p_q;
		// A new edge wins over a read in the same cycle
		flag_d = (rd_clear ? 2'h0 : flag_q) | new_ev;
		// Expiry restores the mask on the same edge, so last cycle's mask still counts
		if (|(new_ev & ~(regs_q[MASK_REG[5:0]][1:0] | mask_p_q)))
			int_d = 32'(INT_CYC);
		else
			int_d = (int_q != 32'h0) ? int_q - 32'h1 : 32'h0;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tick_q      <= 32'h0;
			wd_q        <= 32'h0;
			host_mode_q <= 1'b0;
			safe_q      <= 32'h0;
			safe_exp_q  <= 1'b0;
			flag_q      <= 2'h0;
			stat_p_q    <= 2'h1;
			mask_p_q    <= 2'h0;
			int_q       <= 32'(INT_CYC);
			int_n_q     <= 1'b0;
		end else begin
			tick_q      <= tick_d;
			wd_q        <= wd_d;
			host_mode_q <= host_mode_d;
			safe_q      <= safe_d;
			safe_exp_q  <= safe_exp_d;
			flag_q      <= flag_d;
			stat_p_q    <= stat;
			mask_p_q    <= regs_q[MASK_REG[5:0]][1:0];
			int_q       <= int_d;
			int_n_q     <= (int_d == 32'h0);
		end
	end

	assign int_n               = int_n_q;
	assign host_timeout_status = ~host_mode_q;
	assign charge_active       = ctrl_q[CTRL_CHG] & ~safe_exp_q;

	// ****************************************
	// AHB-Lite register slave
	// ****************************************
	logic        wp_q, wp_d;
	logic [7:0]  wa_q, wa_d;
	logic [1:0]  ctrl_d;
	logic [31:0] hrdata_q, hrdata_d;
	logic        ap;

	assign ap = hsel & htrans[1] & hready;

	always_comb begin
		wp_d     = ap & hwrite;
		wa_d     = haddr[7:0];
		ctrl_d   = ctrl_q;
		hrdata_d = 32'h0;
		if (wp_q && wa_q == AHB_CTRL)
			ctrl_d = hwdata[1:0];
		if (ap && !hwrite) begin
			case (haddr[7:0])
				AHB_CTRL:   hrdata_d = {30'h0, ctrl_q};
				AHB_STATUS: hrdata_d = {28'h0, busy_q, safe_exp_q, flag_q[EV_HTO], ~host_mode_q};
				AHB_PTR:    hrdata_d = {21'h0, st_q, ptr_q};
				default:    hrdata_d = 32'h0;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wp_q     <= 1'b0;
			wa_q     <= 8'h00;
			ctrl_q   <= 2'h0;
			hrdata_q <= 32'h0;
		end else begin
			wp_q     <= wp_d;
			wa_q     <= wa_d;
			ctrl_q   <= ctrl_d;
			hrdata_q <= hrdata_d;
		end
	end

	assign hrdata    = hrdata_q;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_byte_end;
		rise && cnt_q == 3'h7 && !start && !stop;
	endsequence

	AST_ADDR_MISS: assert property (s_byte_end and (st_q == ST_DEV && b[7:1] != I2C_ADDR) |=> st_q == ST_IDLE)
		else $error("foreign address not ignored");
	AST_OOR_READ: assert property ((ptr_q > LAST_REG) |-> rd_byte == 8'hff)
		else $error("out of range read not all ones");
	AST_SDA_CHANGE: assert property ($changed(oe_q) |-> $past(!scl_s_q || start || stop))
		else $error("data changed while clock high");
	AST_START: assert property (start |=> st_q == ST_DEV && !oe_q)
		else $error("start not detected");
	AST_ACK_DRIVE: assert property (st_q == ST_ACK && ackp_q && ack_q |-> oe_q)
		else $error("ack not driven low");
	AST_BAD_PTR: assert property (s_byte_end and (st_q == ST_PTR && b > LAST_REG)
		|=> st_q == ST_ACK && !ack_q && nxt_q == ST_IDLE)
		else $error("bad pointer not refused");
	AST_PTR_INC: assert property (s_byte_end and st_q == ST_WR |=> ptr_q == $past(ptr_q) + 8'h01)
		else $error("pointer did not advance");
	AST_HOST_MODE: assert property (i2c_wr && !wd_exp |=> host_mode_q && wd_q == 32'h0 ##1 !host_timeout_status)
		else $error("write did not enter host mode");
	AST_WD_EXPIRE: assert property (wd_exp |=> !host_mode_q ##1 flag_q[EV_HTO])
		else $error("expiry not handled");
	AST_INT_PULSE: assert property ($fell(int_n) |-> !int_n [*8])
		else $error("interrupt pulse too short");
	AST_FLAG_CLR: assert property (rd_clear && new_ev == 2'h0 |=> flag_q == 2'h0)
		else $error("flag not cleared by read");

endmodule // chs_slave

// *** dv/chs_i2c_master.sv ***
`timescale 1ns/1ps
module chs_i2c_master (
	// Clock and bus lines
	input  wire logic hclk,
	input  wire logic scl,
	input  wire logic sda,
	// Open-drain pulls, high pulls low
	output logic      scl_pull,
	output logic      sda_pull,
	// Stretch wait ran out
	output logic      hung
);
	initial begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
		hung     = 1'b0;
	end

	// ****************************************
	// Bus phases
	// ****************************************
	task automatic q();
		repeat (2) @(posedge hclk);
	endtask

	// Slave may hold the clock low; wait bounded
	task automatic rise();
		int n;
		scl_pull <= 1'b0;
		n = 0;
		while (scl !== 1'b1 && n < 2000) begin
			@(posedge hclk);
			n++;
		end
		if (n >= 2000)
			hung <= 1'b1;
	endtask

	// Works from idle or as a repeated start
	task automatic start();
		sda_pull <= 1'b0;
		q();
		rise();
		q();
		sda_pull <= 1'b1;
		q();
		scl_pull <= 1'b1;
		q();
	endtask

	task automatic stop();
		sda_pull <= 1'b1;
		q();
		rise();
		q();
		sda_pull <= 1'b0;
		q();
	endtask

	// Data moves only while the clock is low
	task automatic bit_x(input logic b, output logic r);
		sda_pull <= !b;
		q();
		rise();
		q();
		r = sda;
		@(posedge hclk);
		scl_pull <= 1'b1;
		q();
	endtask

	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], r);
		bit_x(1'b1, r);
		ack = !r;
	endtask

	// Last byte gets a not-acknowledge
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_x(1'b1, d[i]);
		bit_x(last, r);
	endtask
endmodule // chs_i2c_master

// *** dv/tb_charger_i2c_slave_host_mode.sv ***
`timescale 1ns/1ps
module tb_charger_i2c_slave_host_mode;
	import chs_pkg::*;
	// ****************************************
	// Signals
	// ****************************************
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, lfsr;
	logic        scl_oe, sda_oe, m_scl, m_sda, hung, int_n, hts, chg;
	logic [7:0]  wb [4];
	logic [7:0]  rb [4];
	int          err_count, tests_run, int_low;
	wire         scl = !(scl_oe || m_scl);
	wire         sda = !(sda_oe || m_sda);

	chs_slave #(.INT_CYC(20), .TICK_CYCS(10), .SAFETY_TKS(5), .WD2_TKS(6), .WD3_TKS(40)) DUT (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe),
		.int_n(int_n), .host_timeout_status(hts), .charge_active(chg));
	chs_i2c_master M (.hclk(hclk), .scl(scl), .sda(sda), .scl_pull(m_scl), .sda_pull(m_sda), .hung(hung));

	initial begin
		hclk = 1'b0;
		forever #5 hclk = !hclk;
	end
	always @(posedge hclk) if (int_n === 1'b0) int_low <= int_low + 1;
	always @(posedge hung) begin
		err_count++;
		tally_and_finish();
	end
	initial begin
		repeat (100000) @(posedge hclk);
		err_count++;
		tally_and_finish();
	end

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Zero wait is promised but never assumed
	task automatic waitrdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 100);
		if (n >= 100) begin
			err_count++;
			tally_and_finish();
		end
	endtask

	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= a;
		hwrite <= w;
		hsize  <= 3'h2;
		waitrdy();
		htrans <= 2'h0;
		hsel   <= 1'b0;
		hwdata <= d;
		waitrdy();
		r = hrdata;
	endtask

	task automatic i2c_wr(input logic [7:0] ptr, input int n, input logic ack_exp);
		logic a;
		M.start();
		M.wbyte({I2C_ADDR, 1'b0}, a);
		chk(a, 1);
		M.wbyte(ptr, a);
		chk(a, ack_exp);
		for (int i = 0; i < n; i++) begin
			M.wbyte(wb[i], a);
			chk(a, 1);
		end
		M.stop();
	endtask

	task automatic i2c_rd(input logic [7:0] ptr, input int n);
		logic a;
		M.start();
		M.wbyte({I2C_ADDR, 1'b0}, a);
		M.wbyte(ptr, a);
		M.start();
		M.wbyte({I2C_ADDR, 1'b1}, a);
		chk(a, 1);
		for (int i = 0; i < n; i++)
			M.rbyte(i == n - 1, rb[i]);
		M.stop();
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		logic [31:0] r;
		logic        a;
		hresetn = 1'b0;
		hsel = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		lfsr = 32'h5628;
		int_low = 0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk(int_n, 0);
		chk(hts, 1);
		repeat (30) @(posedge hclk);
		chk(int_n, 1);
		ahb(1'b0, AHB_STATUS, 32'h0, r);
		chk(r[0], 1);
		ahb(1'b0, 32'h40, 32'h0, r);
		chk(r, 0);
		$display("Test done: reset");
		int_low = 0;
		ahb(1'b1, AHB_CTRL, 32'h1, r);
		repeat (3) @(posedge hclk);
		chk(chg, 1);
		repeat (100) @(posedge hclk);
		chk(chg, 0);
		chk(int_low, 20);
		ahb(1'b0, AHB_STATUS, 32'h0, r);
		chk(r[2], 1);
		ahb(1'b1, AHB_CTRL, 32'h0, r);
		$display("Test done: safety timer");
		M.start();
		M.wbyte({I2C_ADDR ^ 7'h01, 1'b0}, a);
		chk(a, 0);
		M.stop();
		i2c_rd(8'h00, 2);
		chk(rb[0], REG_RST[7:0]);
		chk(rb[1], REG_RST[15:8]);
		i2c_rd(LAST_REG, 2);
		chk(rb[0], REG_RST[303:296]);
		chk(rb[1], OOR_DATA);
		i2c_wr(LAST_REG + 8'h01, 0, 1'b0);
		chk(hts, 1);
		$display("Test done: addressing and defaults");
		for (int i = 0; i < 3; i++) begin
			lfsr = nxt(lfsr);
			wb[i] = lfsr[7:0];
		end
		i2c_wr(8'h02, 3, 1'b1);
		chk(hts, 0);
		i2c_rd(8'h02, 3);
		for (int i = 0; i < 3; i++)
			chk(rb[i], wb[i]);
		$display("Test done: multi-byte");
		ahb(1'b1, AHB_CTRL, 32'h2, r);
		fork
			i2c_wr(8'h06, 1, 1'b1);
			begin
				repeat (150) @(posedge hclk);
				chk(scl, 0);
				ahb(1'b0, AHB_STATUS, 32'h0, r);
				chk(r[3], 1);
				ahb(1'b0, AHB_PTR, 32'h0, r);
				chk(r[7:0], 8'h05);
				chk(r[10:8], ST_PTR);
				ahb(1'b1, AHB_CTRL, 32'h0, r);
			end
		join
		$display("Test done: clock stretch");
		wb[0] = 8'h20;
		int_low = 0;
		i2c_wr(WD_REG, 1, 1'b1);
		repeat (300) @(posedge hclk);
		chk(hts, 1);
		chk(int_low, 20);
		i2c_rd(8'h02, 1);
		chk(rb[0], REG_RST[23:16]);
		i2c_rd(FLAG_REG, 1);
		chk(rb[0][EV_HTO], 1);
		i2c_rd(FLAG_REG, 1);
		chk(rb[0][EV_HTO], 0);
		$display("Test done: watchdog");
		wb[0] = 8'h01;
		i2c_wr(MASK_REG, 1, 1'b1);
		wb[0] = 8'h30;
		i2c_wr(WD_REG, 1, 1'b1);
		int_low = 0;
		for (int i = 0; i < 2; i++) begin
			wb[0] = 8'h38;
			i2c_wr(WD_REG, 1, 1'b1);
		end
		chk(hts, 0);
		i2c_rd(WD_REG, 1);
		chk(rb[0], 8'h30);
		repeat (500) @(posedge hclk);
		chk(hts, 1);
		chk(int_low, 0);
		i2c_rd(STAT_REG, 1);
		chk(rb[0][0], 1);
		$display("Test done: kick and mask");
		lfsr = nxt(lfsr);
		wb[0] = lfsr[7:0];
		i2c_wr(8'h00, 1, 1'b1);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk(hts, 1);
		chk(int_n, 0);
		repeat (30) @(posedge hclk);
		i2c_rd(8'h00, 1);
		chk(rb[0], REG_RST[7:0]);
		$display("Test done: reset in mid-run");
		tally_and_finish();
	end
endmodule // tb_charger_i2c_slave_host_mode
